// *** core/bssop_pkg.sv ***
package bssop_pkg;
    localparam int DW = 8;
    localparam int MSB = 7;
    localparam int NIB = 4;
    localparam int SP_W = 8;
    localparam int IO_AW = 5;
    localparam int IO_N = 32;
    localparam logic [SP_W-1:0] SP_RST = 8'hff;
    localparam logic [DW-1:0] DATA_RST = 8'h00;
    localparam logic [DW-1:0] ZERO_B = 8'h00;
    localparam logic [SP_W-1:0] SP_ONE = 8'h01;
    // status flag positions: I T H S V N Z C
    localparam int FLAG_C = 0;
    localparam int FLAG_T = 6;
    localparam int PUSHPOP_CYCLES = 2;

    typedef enum logic [3:0]
    {
        OP_NONE,
        OP_PUSH,
        OP_POP,
        OP_SET_IO_BIT,
        OP_CLEAR_IO_BIT,
        OP_LOGIC_SHIFT_LEFT,
        OP_LOGIC_SHIFT_RIGHT,
        OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY,
        OP_ARITH_SHIFT_RIGHT,
        OP_SWAP_NIBBLES,
        OP_STATUS_FLAG_SET,
        OP_STATUS_FLAG_CLEAR,
        OP_T_FLAG_STORE,
        OP_T_FLAG_LOAD
    } bssop_op_t;

    typedef enum logic
    {
        ST_IDLE,
        ST_SECOND
    } bssop_state_t;
endpackage

// *** core/bssop_stack_mem.sv ***
`timescale 1ns/100ps
module bssop_stack_mem
    import bssop_pkg::*;
(
    // clock
    input  wire logic            clk_i,
    input  wire logic            ce_i,
    // write port
    input  wire logic            we_i,
    input  wire logic [SP_W-1:0] waddr_i,
    input  wire logic [DW-1:0]   wdata_i,
    // read port
    input  wire logic [SP_W-1:0] raddr_i,
    output logic      [DW-1:0]   rdata_o
);
    logic [DW-1:0] mem [0:(1<<SP_W)-1];

    // registered read: data appears one cycle after the address
    always_ff @(posedge clk_i)
    begin
        if (ce_i)
        begin
            if (we_i)
            begin
                mem[waddr_i] <= wdata_i;
            end
            rdata_o <= mem[raddr_i];
        end
    end
endmodule

// *** core/bssop_core.sv ***
// How it works
// - push/pop register via stack, two cycles
// - set/clear one I/O bit, others kept
// - logical shifts fill vacated bit with zero
// - rotate left through carry
// - swap upper and lower nibbles
// - set/clear one status flag only
// - copy source register bit into T
// - copy T into destination bit
`timescale 1ns/100ps
module bssop_core
    import bssop_pkg::*;
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic             ce_i,
    // request from decoder
    input  wire logic             start_i,
    input  wire bssop_op_t        op_i,
    input  wire logic [DW-1:0]    rd_i,
    input  wire logic [DW-1:0]    rr_i,
    input  wire logic [2:0]       bit_i,
    input  wire logic [IO_AW-1:0] io_addr_i,
    // results
    output logic                  busy_o,
    output logic                  done_o,
    output logic                  rd_we_o,
    output logic [DW-1:0]         rd_o,
    output logic [DW-1:0]         status_flags_o,
    output logic [SP_W-1:0]       sp_o,
    output logic [IO_N*DW-1:0]    io_regs_o
);
    typedef struct packed {
        bssop_state_t             state;
        logic                     busy;
        logic                     done;
        logic                     rd_we;
        logic [DW-1:0]            rd;
        logic [DW-1:0]            flags;
        logic [SP_W-1:0]          sp;
        logic [IO_N-1:0][DW-1:0]  io;
        logic                     pop;
    } bssop_regs_t;

    bssop_regs_t r;
    bssop_regs_t next_r;
    logic             mem_we;
    logic [SP_W-1:0]  mem_waddr;
    logic [SP_W-1:0]  mem_raddr;
    logic [DW-1:0]    mem_rdata;
    logic             accept;

    assign accept = start_i && (r.state == ST_IDLE);
    // push writes at sp then decrements; pop pre-increments and reads
    assign mem_we    = accept && (op_i == OP_PUSH);
    assign mem_waddr = r.sp;
    assign mem_raddr = r.sp + SP_ONE;

    bssop_stack_mem i_bssop_stack_mem
    (
        .clk_i   (clk_i),
        .ce_i    (ce_i),
        .we_i    (mem_we),
        .waddr_i (mem_waddr),
        .wdata_i (rr_i),
        .raddr_i (mem_raddr),
        .rdata_o (mem_rdata)
    );

    always_comb
    begin
        next_r       = r;
        next_r.done  = 1'b0;
        next_r.rd_we = 1'b0;
        case (r.state)
            ST_IDLE:
            begin
                if (start_i)
                begin
                    next_r.done = 1'b1;
                    case (op_i)
                        OP_PUSH, OP_POP:
                        begin
                            // two-cycle ops: busy now, done in the second cycle
                            next_r.done  = 1'b0;
                            next_r.busy  = 1'b1;
                            next_r.state = ST_SECOND;
                        end
                        OP_SET_IO_BIT:
                            next_r.io[io_addr_i][bit_i] = 1'b1;
                        OP_CLEAR_IO_BIT:
                            next_r.io[io_addr_i][bit_i] = 1'b0;
                        OP_LOGIC_SHIFT_LEFT:
                        begin
                            next_r.rd    = {rd_i[MSB-1:0], 1'b0};
                            next_r.rd_we = 1'b1;
                        end
                        OP_LOGIC_SHIFT_RIGHT:
                        begin
                            next_r.rd    = {1'b0, rd_i[MSB:1]};
                            next_r.rd_we = 1'b1;
                        end
                        OP_ROTATE_LEFT_CARRY:
                        begin
                            next_r.rd            = {rd_i[MSB-1:0], r.flags[FLAG_C]};
                            next_r.flags[FLAG_C] = rd_i[MSB];
                            next_r.rd_we         = 1'b1;
                        end
                        OP_ROTATE_RIGHT_CARRY:
                        begin
                            next_r.rd            = {r.flags[FLAG_C], rd_i[MSB:1]};
                            next_r.flags[FLAG_C] = rd_i[0];
                            next_r.rd_we         = 1'b1;
                        end
                        OP_ARITH_SHIFT_RIGHT:
                        begin
                            next_r.rd    = {rd_i[MSB], rd_i[MSB:1]};
                            next_r.rd_we = 1'b1;
                        end
                        OP_SWAP_NIBBLES:
                        begin
                            next_r.rd    = {rd_i[NIB-1:0], rd_i[MSB:NIB]};
                            next_r.rd_we = 1'b1;
                        end
                        OP_STATUS_FLAG_SET:
                            next_r.flags[bit_i] = 1'b1;
                        OP_STATUS_FLAG_CLEAR:
                            next_r.flags[bit_i] = 1'b0;
                        OP_T_FLAG_STORE:
                            next_r.flags[FLAG_T] = rr_i[bit_i];
                        OP_T_FLAG_LOAD:
                        begin
                            next_r.rd        = rd_i;
                            next_r.rd[bit_i] = r.flags[FLAG_T];
                            next_r.rd_we     = 1'b1;
                        end
                        default:
                            next_r.done = 1'b0;
                    endcase
                    if (op_i == OP_PUSH)
                    begin
                        next_r.sp = r.sp - SP_ONE;
                    end
                    if (op_i == OP_POP)
                    begin
                        next_r.sp = r.sp + SP_ONE;
                    end
                    // remembers that the second cycle must take the popped byte
                    next_r.pop = (op_i == OP_POP);
                end
            end
            ST_SECOND:
            begin
                // pop data arrives from the registered memory port here
                next_r.state = ST_IDLE;
                next_r.busy  = 1'b0;
                next_r.done  = 1'b1;
                if (r.busy && r.pop)
                begin
                    next_r.rd    = mem_rdata;
                    next_r.rd_we = 1'b1;
                end
            end
            default:
                next_r.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            r.state <= ST_IDLE;
            r.busy  <= 1'b0;
            r.done  <= 1'b0;
            r.rd_we <= 1'b0;
            r.rd    <= DATA_RST;
            r.flags <= DATA_RST;
            r.sp    <= SP_RST;
            r.io    <= '0;
            r.pop   <= 1'b0;
        end
        else if (ce_i)
        begin
            r <= next_r;
        end
    end

    assign busy_o         = r.busy;
    assign done_o         = r.done;
    assign rd_we_o        = r.rd_we;
    assign rd_o           = r.rd;
    assign status_flags_o = r.flags;
    assign sp_o           = r.sp;
    assign io_regs_o      = r.io;

    // a push or pop completes exactly two cycles after it is taken
    sequence s_stack_start;
        start_i && ce_i && (r.state == ST_IDLE) && (op_i == OP_PUSH || op_i == OP_POP);
    endsequence

    sequence s_stack_finish;
        ce_i && busy_o ##1 done_o;
    endsequence

    a_stack_two_cycle: assert property (@(posedge clk_i) disable iff (srst_i)
        s_stack_start |=> s_stack_finish)
        else $error("push or pop not done in two cycles");

    a_shift_left_zero: assert property (@(posedge clk_i) disable iff (srst_i)
        (accept && ce_i && op_i == OP_LOGIC_SHIFT_LEFT) |=> (rd_o == {$past(rd_i[MSB-1:0]), 1'b0}))
        else $error("left shift result wrong");

    a_shift_right_zero: assert property (@(posedge clk_i) disable iff (srst_i)
        (accept && ce_i && op_i == OP_LOGIC_SHIFT_RIGHT) |=> (rd_o[MSB] == 1'b0 && rd_we_o))
        else $error("right shift top bit not zero");

    a_rotl_carry: assert property (@(posedge clk_i) disable iff (srst_i)
        (accept && ce_i && op_i == OP_ROTATE_LEFT_CARRY) |=>
        (status_flags_o[FLAG_C] == $past(rd_i[MSB]) && rd_o[0] == $past(r.flags[FLAG_C])))
        else $error("rotate left carry wrong");

    a_rotr_carry: assert property (@(posedge clk_i) disable iff (srst_i)
        (accept && ce_i && op_i == OP_ROTATE_RIGHT_CARRY) |=>
        (status_flags_o[FLAG_C] == $past(rd_i[0]) && rd_o[MSB] == $past(r.flags[FLAG_C])))
        else $error("rotate right carry wrong");

    a_asr_sign: assert property (@(posedge clk_i) disable iff (srst_i)
        (accept && ce_i && op_i == OP_ARITH_SHIFT_RIGHT) |=>
        (rd_o == {$past(rd_i[MSB]), $past(rd_i[MSB:1])} && rd_we_o))
        else $error("arithmetic shift lost sign");

    a_swap_nibble: assert property (@(posedge clk_i) disable iff (srst_i)
        (accept && ce_i && op_i == OP_SWAP_NIBBLES) |=> (rd_o == {$past(rd_i[NIB-1:0]), $past(rd_i[MSB:NIB])}))
        else $error("nibble swap wrong");

    a_flag_set_bit: assert property (@(posedge clk_i) disable iff (srst_i)
        (accept && ce_i && op_i == OP_STATUS_FLAG_SET) |=> status_flags_o[$past(bit_i)])
        else $error("flag not set");

    a_io_set_bit: assert property (@(posedge clk_i) disable iff (srst_i)
        (accept && ce_i && op_i == OP_SET_IO_BIT) |=> r.io[$past(io_addr_i)][$past(bit_i)])
        else $error("io bit not set");

    a_t_store_bit: assert property (@(posedge clk_i) disable iff (srst_i)
        (accept && ce_i && op_i == OP_T_FLAG_STORE) |=> (status_flags_o[FLAG_T] == $past(rr_i[bit_i])))
        else $error("t store wrong");

    a_t_load_bit: assert property (@(posedge clk_i) disable iff (srst_i)
        (accept && ce_i && op_i == OP_T_FLAG_LOAD) |=> (rd_o[$past(bit_i)] == $past(r.flags[FLAG_T])))
        else $error("t load wrong");
endmodule

// *** tb/bssop_core_test.sv ***
`timescale 1ns/100ps
module bssop_core_test
    import bssop_pkg::*;
;
    logic                  clk_i;
    logic                  srst_i;
    logic                  ce_i;
    logic                  start_i;
    bssop_op_t             op_i;
    logic [DW-1:0]         rd_i;
    logic [DW-1:0]         rr_i;
    logic [2:0]            bit_i;
    logic [IO_AW-1:0]      io_addr_i;
    logic                  busy_o;
    logic                  done_o;
    logic                  rd_we_o;
    logic [DW-1:0]         rd_o;
    logic [DW-1:0]         status_flags_o;
    logic [SP_W-1:0]       sp_o;
    logic [IO_N*DW-1:0]    io_regs_o;
    int                    err_total;
    int                    comparisons;
    int                    lat;
    logic                  we;

    bssop_core i_bssop_core (
        .clk_i          (clk_i),
        .srst_i         (srst_i),
        .ce_i           (ce_i),
        .start_i        (start_i),
        .op_i           (op_i),
        .rd_i           (rd_i),
        .rr_i           (rr_i),
        .bit_i          (bit_i),
        .io_addr_i      (io_addr_i),
        .busy_o         (busy_o),
        .done_o         (done_o),
        .rd_we_o        (rd_we_o),
        .rd_o           (rd_o),
        .status_flags_o (status_flags_o),
        .sp_o           (sp_o),
        .io_regs_o      (io_regs_o)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // issue one request, then wait for done with a bounded count; lat holds extra cycles
    task automatic run(input bssop_op_t op, input logic [7:0] d, input logic [7:0] s, input logic [2:0] b,
                       input logic [4:0] a);
        @(posedge clk_i);
        start_i <= 1'b1;
        op_i <= op;
        rd_i <= d;
        rr_i <= s;
        bit_i <= b;
        io_addr_i <= a;
        @(posedge clk_i);
        start_i <= 1'b0;
        #1;
        lat = 0;
        while (done_o !== 1'b1 && lat < 8)
        begin
            if (busy_o !== 1'b1)
                lat = 100;
            @(posedge clk_i);
            #1;
            lat++;
        end
        we = rd_we_o;
        if (lat >= 8)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, lat, 0);
            stop_test();
        end
    endtask

    task automatic test_flags();
        logic [7:0] exp;
        exp = 8'h00;
        for (int b = 0; b < 8; b++)
        begin
            run(OP_STATUS_FLAG_SET, 8'h00, 8'h00, 3'(b), 5'h00);
            exp[b] = 1'b1;
            chk(status_flags_o, exp);
        end
        for (int b = 7; b >= 0; b--)
        begin
            run(OP_STATUS_FLAG_CLEAR, 8'h00, 8'h00, 3'(b), 5'h00);
            exp[b] = 1'b0;
            chk(status_flags_o, exp);
        end
        $display("test flags done");
    endtask

    task automatic test_tbit();
        run(OP_T_FLAG_STORE, 8'h00, 8'h20, 3'h5, 5'h00);
        chk(status_flags_o, 8'h40);
        run(OP_T_FLAG_LOAD, 8'h00, 8'h00, 3'h2, 5'h00);
        chk({7'h00, we}, 8'h01);
        chk(rd_o, 8'h04);
        run(OP_T_FLAG_STORE, 8'h00, 8'h20, 3'h0, 5'h00);
        chk(status_flags_o, 8'h00);
        run(OP_T_FLAG_LOAD, 8'hff, 8'h00, 3'h7, 5'h00);
        chk(rd_o, 8'h7f);
        $display("test tbit done");
    endtask

    // carry enters at one end and leaves from the other, so chain the results
    task automatic test_rotate();
        run(OP_STATUS_FLAG_CLEAR, 8'h00, 8'h00, 3'h0, 5'h00);
        run(OP_ROTATE_LEFT_CARRY, 8'h81, 8'h00, 3'h0, 5'h00);
        chk(rd_o, 8'h02);
        chk(status_flags_o, 8'h01);
        run(OP_ROTATE_LEFT_CARRY, 8'h40, 8'h00, 3'h0, 5'h00);
        chk(rd_o, 8'h81);
        chk(status_flags_o, 8'h00);
        run(OP_ROTATE_RIGHT_CARRY, 8'h01, 8'h00, 3'h0, 5'h00);
        chk(rd_o, 8'h00);
        chk(status_flags_o, 8'h01);
        run(OP_ROTATE_RIGHT_CARRY, 8'h00, 8'h00, 3'h0, 5'h00);
        chk(rd_o, 8'h80);
        chk(status_flags_o, 8'h00);
        $display("test rotate done");
    endtask

    task automatic test_stack();
        run(OP_PUSH, 8'h00, 8'ha5, 3'h0, 5'h00);
        chk(8'(lat), 8'h01);
        chk(sp_o, 8'hfe);
        run(OP_PUSH, 8'h00, 8'h3c, 3'h0, 5'h00);
        chk(sp_o, 8'hfd);
        run(OP_POP, 8'h00, 8'h00, 3'h0, 5'h00);
        chk(8'(lat), 8'h01);
        chk({we, rd_o[6:0]}, 8'hbc);
        run(OP_POP, 8'h00, 8'h00, 3'h0, 5'h00);
        chk(rd_o, 8'ha5);
        chk(sp_o, 8'hff);
        $display("test stack done");
    endtask

    task automatic test_io();
        run(OP_SET_IO_BIT, 8'h00, 8'h00, 3'h3, 5'h1f);
        chk(io_regs_o[255:248], 8'h08);
        run(OP_SET_IO_BIT, 8'h00, 8'h00, 3'h7, 5'h1f);
        chk(io_regs_o[255:248], 8'h88);
        run(OP_CLEAR_IO_BIT, 8'h00, 8'h00, 3'h3, 5'h1f);
        chk(io_regs_o[255:248], 8'h80);
        chk(io_regs_o[247:240], 8'h00);
        $display("test io done");
    endtask

    task automatic test_shift();
        run(OP_LOGIC_SHIFT_LEFT, 8'h81, 8'h00, 3'h0, 5'h00);
        chk(rd_o, 8'h02);
        run(OP_LOGIC_SHIFT_RIGHT, 8'h81, 8'h00, 3'h0, 5'h00);
        chk(rd_o, 8'h40);
        run(OP_ARITH_SHIFT_RIGHT, 8'h81, 8'h00, 3'h0, 5'h00);
        chk(rd_o, 8'hc0);
        run(OP_ARITH_SHIFT_RIGHT, 8'h7e, 8'h00, 3'h0, 5'h00);
        chk(rd_o, 8'h3f);
        run(OP_SWAP_NIBBLES, 8'h5a, 8'h00, 3'h0, 5'h00);
        chk(rd_o, 8'ha5);
        $display("test shift done");
    endtask

    // a request while busy and an empty operation must both be ignored
    task automatic test_refuse();
        logic [7:0] flags_before;
        logic [7:0] sp_before;
        flags_before = status_flags_o;
        sp_before = sp_o;
        @(posedge clk_i);
        start_i <= 1'b1;
        op_i <= OP_PUSH;
        rr_i <= 8'h77;
        @(posedge clk_i);
        op_i <= OP_STATUS_FLAG_SET;
        bit_i <= 3'h2;
        @(posedge clk_i);
        op_i <= OP_NONE;
        #1;
        chk({6'h00, busy_o, done_o}, 8'h01);
        @(posedge clk_i);
        start_i <= 1'b0;
        #1;
        chk({7'h00, done_o}, 8'h00);
        chk(status_flags_o, flags_before);
        chk(sp_o, sp_before - 8'h01);
        $display("test refuse done");
    endtask

    // with the clock enable low a request must leave every output frozen
    task automatic test_ce();
        logic [7:0] flags_before;
        flags_before = status_flags_o;
        @(posedge clk_i);
        ce_i <= 1'b0;
        start_i <= 1'b1;
        op_i <= OP_STATUS_FLAG_SET;
        bit_i <= 3'h4;
        repeat (3) @(posedge clk_i);
        #1;
        chk({7'h00, done_o}, 8'h00);
        chk(status_flags_o, flags_before);
        @(posedge clk_i);
        ce_i <= 1'b1;
        start_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(status_flags_o, flags_before);
        $display("test ce done");
    endtask

    // a reset between requests must restore every register, then the next request works
    task automatic test_reset();
        run(OP_STATUS_FLAG_SET, 8'h00, 8'h00, 3'h7, 5'h00);
        @(posedge clk_i);
        srst_i <= 1'b1;
        @(posedge clk_i);
        srst_i <= 1'b0;
        #1;
        chk(sp_o, SP_RST);
        chk(status_flags_o, 8'h00);
        chk(io_regs_o[255:248], 8'h00);
        chk(rd_o, 8'h00);
        chk({5'h00, busy_o, done_o, rd_we_o}, 8'h00);
        run(OP_STATUS_FLAG_SET, 8'h00, 8'h00, 3'h0, 5'h00);
        chk(status_flags_o, 8'h01);
        $display("test reset done");
    endtask

    initial
    begin
        err_total = 0;
        comparisons = 0;
        srst_i = 1'b1;
        ce_i = 1'b1;
        start_i = 1'b0;
        op_i = OP_NONE;
        rd_i = 8'h00;
        rr_i = 8'h00;
        bit_i = 3'h0;
        io_addr_i = 5'h00;
        repeat (12) @(posedge clk_i);
        srst_i <= 1'b0;
        test_flags();
        test_tbit();
        test_rotate();
        test_stack();
        test_io();
        test_shift();
        test_refuse();
        test_ce();
        test_reset();
        stop_test();
    end
endmodule
